// file: core/msf_accum.sv
`timescale 1ns/100ps
// Per-period accumulator: sums samples, dumps the sum on each period strobe
module msf_accum (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic add,
   input wire logic [15:0] value,
   input wire logic dump,
   output logic [31:0] result
);
   import msf_pkg::*;
   logic [31:0] sum;
   wire [31:0] ext = {{16{value[15]}}, value};
   wire [31:0] next_sum = sum + ext;
   // Running sum and latched result
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sum <= ZERO32;
         result <= ZERO32;
      end else if (dump) begin
         // A sample on the dump cycle opens the new period
         result <= sum;
         sum <= add ? ext : ZERO32;
      end else if (add) begin
         sum <= next_sum;
      end
   end
endmodule

// file: core/msf_pkg.sv
package msf_pkg;
   // APB register map (byte addresses)
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_EVENT_EN = 8'h08;
   localparam logic [7:0] ADDR_COMMAND = 8'h0c;
   localparam logic [7:0] ADDR_MSG = 8'h10;
   localparam logic [7:0] ADDR_PERIOD = 8'h14;
   localparam logic [7:0] ADDR_LOAD = 8'h18;
   localparam logic [7:0] ADDR_CYCLES = 8'h1c;
   localparam logic [7:0] ADDR_LEVEL = 8'h20;
   // Status flag positions
   localparam int FB_TAMPER = 0;
   localparam int FB_CALRDY = 1;
   localparam int FB_TRAIL = 2;
   localparam int FB_LEAD = 3;
   localparam int FB_ENRDY = 4;
   localparam int FB_LEVEL = 5;
   localparam int FB_LARGER = 6;
   localparam int FB_SAMPLE = 7;
   localparam int FB_UNDERV = 8;
   localparam int NFLAGS = 16;
   // Control bits
   localparam int CB_COUNT_SEL = 0;
   localparam int CB_SECOND_I = 1;
   // Command word bit for the clear-event command
   localparam int CMD_CLEAR_EVENT = 0;
   // Load-type window in mains periods
   localparam logic [11:0] LOAD_WINDOW_LAST = 12'hfff;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [15:0] ONE16 = 16'h0001;
   // Engine modes
   typedef enum logic [1:0] {
      MSF_IDLE = 2'b00,
      MSF_MEASURE = 2'b01,
      MSF_CALIB = 2'b11
   } msf_mode_t;
endpackage

// file: core/msf_rise_msg.sv
`timescale 1ns/100ps
// Detects a 0-to-1 change on an enabled flag and holds a message until read
module msf_rise_msg (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic flag,
   input wire logic enable,
   input wire logic take,
   output logic pending,
   output logic sent
);
   logic flag_q;
   wire rise = flag & ~flag_q;
   wire fire = rise & enable;
   // Sent pulses when the CPU takes a pending message
   assign sent = pending & take;
   // Previous flag value
   always_ff @(posedge ref_clk) begin
      if (!rst_n) flag_q <= 1'b0;
      else flag_q <= flag;
   end
   // Message latch, a new rise wins over the take
   always_ff @(posedge ref_clk) begin
      if (!rst_n) pending <= 1'b0;
      else if (fire) pending <= 1'b1;
      else if (take) pending <= 1'b0;
   end
endmodule

// file: core/msf_status.sv
`timescale 1ns/100ps
module msf_status (
   input wire logic ref_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Engine events
   input wire msf_pkg::msf_mode_t engine_mode,
   input wire logic tamper_event,
   input wire logic calib_done,
   input wire logic voltage_sign,
   input wire logic sample_strobe,
   input wire logic [15:0] voltage_wave_sample,
   input wire logic [15:0] current_a_wave_sample,
   input wire logic [15:0] current_b_wave_sample,
   input wire logic results_ready,
   input wire logic [15:0] energy_step,
   input wire logic capacitive_load,
   input wire logic undervoltage_seen,
   input wire logic current_b_larger,
   // Engine side effects
   output logic temp_start,
   output logic [15:0] engine_status_flags,
   output logic message_pending,
   output logic [15:0] mains_period_value,
   output logic [15:0] load_type_register,
   output logic [15:0] line_cycle_counter,
   output logic [31:0] period_active_energy_a,
   output logic [31:0] period_active_energy_b,
   output logic [15:0] voltage_peak_register,
   output logic [15:0] current_peak_register
);
   import msf_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [1:0] engine_control_word;
   logic [NFLAGS-1:0] event_enable;
   logic [31:0] interrupt_level_parameter;
   logic [31:0] level_accum;
   logic sign_q;
   logic sign_valid;
   logic temp_pending;
   logic [15:0] period_count;
   logic [15:0] load_counter;
   logic [11:0] load_periods;
   logic [15:0] v_peak_run;
   logic [15:0] i_peak_run;
   logic [NFLAGS-1:0] msg_pend;
   logic [NFLAGS-1:0] msg_sent;
   logic [NFLAGS-1:0] msg_take;

   ////////////////////////////////////////////////////////////////////
   // APB decode
   wire apb_access = psel & penable;
   wire apb_wr = apb_access & pwrite;
   wire hit_status = (paddr == ADDR_STATUS);
   wire hit_control = (paddr == ADDR_CONTROL);
   wire hit_event = (paddr == ADDR_EVENT_EN);
   wire hit_command = (paddr == ADDR_COMMAND);
   wire hit_msg = (paddr == ADDR_MSG);
   wire hit_period = (paddr == ADDR_PERIOD);
   wire hit_load = (paddr == ADDR_LOAD);
   wire hit_cycles = (paddr == ADDR_CYCLES);
   wire hit_level = (paddr == ADDR_LEVEL);
   wire hit_any = hit_status | hit_control | hit_event | hit_command | hit_msg
                  | hit_period | hit_load | hit_cycles | hit_level;
   wire clear_event_command = apb_wr & hit_command & pwdata[CMD_CLEAR_EVENT];
   wire msg_read = apb_access & ~pwrite & hit_msg;
   assign pready = 1'b1;
   assign pslverr = apb_access & ~hit_any;
   // Read of the message register hands every pending message over
   assign msg_take = msg_read ? msg_pend : {NFLAGS{1'b0}};

   ////////////////////////////////////////////////////////////////////
   // Crossing detection
   // Crossings exist only on a sample strobe; the sign level alone is not sampled
   wire trail_x = sample_strobe & sign_valid & ~sign_q & voltage_sign;  // sign=1 means negative
   wire lead_x = sample_strobe & sign_valid & sign_q & ~voltage_sign;
   wire count_sel = engine_control_word[CB_COUNT_SEL];
   wire second_i = engine_control_word[CB_SECOND_I];
   wire [31:0] lvl_inc = count_sel ? {16'h0000, ONE16}
                                   : {{16{energy_step[15]}}, energy_step};
   wire [31:0] next_level = level_accum + lvl_inc;
   wire lvl_hit = results_ready & (next_level >= interrupt_level_parameter);
   wire [15:0] v_abs = voltage_wave_sample[15] ? 16'(-voltage_wave_sample)
                                               : voltage_wave_sample;
   wire [15:0] ia_abs = current_a_wave_sample[15] ? 16'(-current_a_wave_sample)
                                                  : current_a_wave_sample;
   wire [15:0] ib_abs = current_b_wave_sample[15] ? 16'(-current_b_wave_sample)
                                                  : current_b_wave_sample;
   wire [15:0] i_abs = (second_i && ib_abs > ia_abs) ? ib_abs : ia_abs;
   wire [15:0] next_load = capacitive_load ? 16'(load_counter + ONE16)
                                           : 16'(load_counter - ONE16);

   // Sample sign history
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         sign_q <= 1'b0;
         sign_valid <= 1'b0;
      end else if (sample_strobe) begin
         sign_q <= voltage_sign;
         sign_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Status flags
   logic [NFLAGS-1:0] flags;
   assign engine_status_flags = flags;
   assign message_pending = |msg_pend;
   wire [NFLAGS-1:0] clr_evt = msg_sent | (clear_event_command
                              ? (NFLAGS'(1) << FB_ENRDY | NFLAGS'(1) << FB_LEVEL
                                 | NFLAGS'(1) << FB_SAMPLE) : {NFLAGS{1'b0}});

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flags <= {NFLAGS{1'b0}};
      end else begin
         if (tamper_event) flags[FB_TAMPER] <= 1'b1;
         if (engine_mode == MSF_IDLE) flags[FB_CALRDY] <= 1'b0;
         else if (engine_mode == MSF_CALIB && calib_done) flags[FB_CALRDY] <= 1'b1;
         if (trail_x) flags[FB_TRAIL] <= 1'b1;
         else if (lead_x) flags[FB_TRAIL] <= 1'b0;
         if (lead_x) flags[FB_LEAD] <= 1'b1;
         else if (trail_x) flags[FB_LEAD] <= 1'b0;
         if (trail_x) flags[FB_UNDERV] <= undervoltage_seen;
         // Set wins over clear on the same edge
         if (results_ready) flags[FB_ENRDY] <= 1'b1;
         else if (clr_evt[FB_ENRDY]) flags[FB_ENRDY] <= 1'b0;
         if (lvl_hit) flags[FB_LEVEL] <= 1'b1;
         else if (clr_evt[FB_LEVEL]) flags[FB_LEVEL] <= 1'b0;
         flags[FB_LARGER] <= second_i & current_b_larger;
         // Sample flag rises on every sample strobe, crossing strobes included
         if (sample_strobe) flags[FB_SAMPLE] <= 1'b1;
         else if (clr_evt[FB_SAMPLE]) flags[FB_SAMPLE] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mailbox messages, one detector per flag
   genvar g;
   generate
      for (g = 0; g < NFLAGS; g++) begin : g_msg
         msf_rise_msg u_msg (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .flag(flags[g]),
            .enable(event_enable[g]),
            .take(msg_take[g]),
            .pending(msg_pend[g]),
            .sent(msg_sent[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Crossing tasks
   // Temperature start request, issued at either crossing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         temp_pending <= 1'b0;
         temp_start <= 1'b0;
      end else begin
         temp_start <= (trail_x | lead_x) & temp_pending;
         // A new request wins over the crossing that consumes the old one
         if (results_ready) temp_pending <= 1'b1;
         else if (trail_x | lead_x) temp_pending <= 1'b0;
      end
   end

   // Mains period in samples, stored at each leading crossing
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         period_count <= ZERO16;
         mains_period_value <= ZERO16;
      end else if (lead_x) begin
         mains_period_value <= period_count;
         period_count <= ONE16;
      end else if (sample_strobe) begin
         period_count <= 16'(period_count + ONE16);
      end
   end

   // Load type accumulation, published every window of mains periods
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         load_counter <= ZERO16;
         load_periods <= 12'h000;
         load_type_register <= ZERO16;
      end else if (lead_x) begin
         load_periods <= 12'(load_periods + 12'h001);
         if (load_periods == LOAD_WINDOW_LAST) begin
            load_type_register <= next_load;
            load_counter <= ZERO16;
         end else begin
            load_counter <= next_load;
         end
      end
   end

   // Line cycles and peaks
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         line_cycle_counter <= ZERO16;
         voltage_peak_register <= ZERO16;
         current_peak_register <= ZERO16;
         v_peak_run <= ZERO16;
         i_peak_run <= ZERO16;
      end else if (lead_x) begin
         line_cycle_counter <= 16'(line_cycle_counter + ONE16);
         voltage_peak_register <= v_peak_run;
         current_peak_register <= i_peak_run;
         // The crossing sample opens the new period
         v_peak_run <= v_abs;
         i_peak_run <= i_abs;
      end else if (sample_strobe) begin
         if (v_abs > v_peak_run) v_peak_run <= v_abs;
         if (i_abs > i_peak_run) i_peak_run <= i_abs;
      end
   end

   // Per-period energies of both current channels
   msf_accum u_acc_a (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .add(sample_strobe),
      .value(current_a_wave_sample),
      .dump(lead_x),
      .result(period_active_energy_a)
   );
   msf_accum u_acc_b (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .add(sample_strobe),
      .value(current_b_wave_sample),
      .dump(lead_x),
      .result(period_active_energy_b)
   );

   // Interrupt level accumulation in energy or count mode
   always_ff @(posedge ref_clk) begin
      if (!rst_n) level_accum <= ZERO32;
      else if (lvl_hit) level_accum <= ZERO32;
      else if (results_ready) level_accum <= next_level;
   end

   ////////////////////////////////////////////////////////////////////
   // Software writable registers
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         engine_control_word <= 2'b00;
         event_enable <= {NFLAGS{1'b0}};
         interrupt_level_parameter <= ZERO32;
      end else if (apb_wr) begin
         if (hit_control) engine_control_word <= pwdata[1:0];
         if (hit_event) event_enable <= pwdata[NFLAGS-1:0];
         if (hit_level) interrupt_level_parameter <= pwdata;
      end
   end

   // Read mux, combinational data
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = ZERO32;
      if (hit_status) rd_mux = {16'h0000, flags};  // Read only, writes ignored
      if (hit_control) rd_mux = {30'h0, engine_control_word};
      if (hit_event) rd_mux = {16'h0000, event_enable};
      if (hit_msg) rd_mux = {16'h0000, msg_pend};
      if (hit_period) rd_mux = {16'h0000, mains_period_value};
      if (hit_load) rd_mux = {16'h0000, load_type_register};
      if (hit_cycles) rd_mux = {16'h0000, line_cycle_counter};
      if (hit_level) rd_mux = interrupt_level_parameter;
   end
   assign prdata = rd_mux;
endmodule

// file: verif/msf_host.sv
`timescale 1ns/100ps
// Host side APB master; each transfer is followed by one idle cycle
module msf_host (
   input wire logic ref_clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0000_0000
);
   // Setup, access held until pready, then release
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
      if (n >= 50) begin
         testbench.error_cnt++;
         testbench.complete_run();
      end
   endtask
endmodule

// file: verif/msf_status_sva.sv
`timescale 1ns/100ps
module msf_chk import msf_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire msf_pkg::msf_mode_t engine_mode,
   input wire logic tamper_event,
   input wire logic calib_done,
   input wire logic voltage_sign,
   input wire logic sample_strobe,
   input wire logic results_ready,
   input wire logic [15:0] engine_status_flags,
   input wire logic message_pending
);
   logic last_sign, seen, sec_en, smp_en;
   wire logic [15:0] f = engine_status_flags;
   wire logic wr_acc = psel && penable && pwrite;
   wire logic clr_cmd = wr_acc && paddr == ADDR_COMMAND && pwdata[CMD_CLEAR_EVENT];
   wire logic quiet = !results_ready && !sample_strobe && !tamper_event;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the last sampled sign and of the enables software wrote
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         last_sign <= 1'b0;
         seen <= 1'b0;
         sec_en <= 1'b0;
         smp_en <= 1'b0;
      end else begin
         if (sample_strobe) begin
            last_sign <= voltage_sign;
            seen <= 1'b1;
         end
         if (wr_acc && paddr == ADDR_CONTROL) begin
            sec_en <= pwdata[CB_SECOND_I];
         end
         if (wr_acc && paddr == ADDR_EVENT_EN) begin
            smp_en <= pwdata[FB_SAMPLE];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Crossing detections seen on a sample strobe
   sequence s_trail; sample_strobe && seen && voltage_sign && !last_sign; endsequence
   sequence s_lead; sample_strobe && seen && !voltage_sign && last_sign; endsequence
   property p_tamper_set; tamper_event |=> f[FB_TAMPER]; endproperty
   property p_tamper_hold; f[FB_TAMPER] |=> f[FB_TAMPER]; endproperty
   property p_trail; s_trail |=> f[FB_TRAIL] && !f[FB_LEAD] && f[FB_SAMPLE]; endproperty
   property p_lead; s_lead |=> f[FB_LEAD] && !f[FB_TRAIL] && f[FB_SAMPLE]; endproperty
   property p_cal_set; calib_done && engine_mode == MSF_CALIB |=> f[FB_CALRDY]; endproperty
   property p_cal_idle; engine_mode == MSF_IDLE |=> !f[FB_CALRDY]; endproperty
   property p_enrdy; results_ready |=> f[FB_ENRDY]; endproperty
   property p_clear;
      clr_cmd && quiet |=> !f[FB_ENRDY] && !f[FB_LEVEL] && !f[FB_SAMPLE]
         && $stable({f[FB_LEAD], f[FB_TRAIL], f[FB_TAMPER]});
   endproperty
   property p_larger; !sec_en && !$past(sec_en) |-> !f[FB_LARGER]; endproperty
   property p_msg; sample_strobe && smp_en && !f[FB_SAMPLE] |-> ##[1:2] message_pending; endproperty
   a_tamper_set: assert property (p_tamper_set) else $error("tamper flag not set");
   a_tamper_hold: assert property (p_tamper_hold) else $error("tamper flag cleared");
   a_trail: assert property (p_trail) else $error("trailing crossing flags wrong");
   a_lead: assert property (p_lead) else $error("leading crossing flags wrong");
   a_cal_set: assert property (p_cal_set) else $error("calibration flag not set");
   a_cal_idle: assert property (p_cal_idle) else $error("calibration flag kept in idle");
   a_enrdy: assert property (p_enrdy) else $error("energy ready not set");
   a_clear: assert property (p_clear) else $error("clear event mismatch");
   a_larger: assert property (p_larger) else $error("larger current flag while off");
   a_msg: assert property (p_msg) else $error("no message on enabled rise");
endmodule
bind msf_status msf_chk i_chk (
   .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .engine_mode, .tamper_event,
   .calib_done, .voltage_sign, .sample_strobe, .results_ready, .engine_status_flags,
   .message_pending
);

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
   import msf_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, tamper_event = 1'b0, calib_done = 1'b0;
   logic voltage_sign = 1'b0, sample_strobe = 1'b0, results_ready = 1'b0, pe;
   logic capacitive_load = 1'b1, undervoltage_seen = 1'b0, current_b_larger = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, message_pending;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, pa;
   logic [15:0] wave = 16'h0010, energy_step = 16'h0001, flags, line_cycle_counter;
   logic [15:0] mains_period_value, load_type_register, voltage_peak_register;
   logic [15:0] current_peak_register;
   logic [31:0] period_active_energy_a, period_active_energy_b;
   logic temp_start;
   msf_mode_t engine_mode = MSF_MEASURE;
   int error_cnt = 0, checked = 0, temp_cnt = 0;
   always #10 ref_clk = ~ref_clk;
   // Counts one-cycle temperature start pulses
   always @(posedge ref_clk) begin
      if (temp_start === 1'b1) temp_cnt <= temp_cnt + 1;
   end
   msf_status i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .engine_mode, .tamper_event, .calib_done, .voltage_sign,
      .sample_strobe, .voltage_wave_sample(wave), .current_a_wave_sample(wave),
      .current_b_wave_sample(~wave), .results_ready, .energy_step, .capacitive_load,
      .undervoltage_seen, .current_b_larger, .temp_start, .engine_status_flags(flags),
      .message_pending, .mains_period_value, .load_type_register, .line_cycle_counter,
      .period_active_energy_a, .period_active_energy_b, .voltage_peak_register,
      .current_peak_register);
   msf_host i_host (.ref_clk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
      .pwdata);
   ////////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task tick(input int n); repeat (n) @(posedge ref_clk); endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d); i_host.xfer(a, 1'b1, d, pa, pe); endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input string m);
      i_host.xfer(a, 1'b0, 32'h0, pa, pe);
      chk(pa, exp, m);
   endtask
   task strobe(input logic s);
      voltage_sign <= s;
      sample_strobe <= 1'b1;
      wave <= wave + 16'h0101;
      tick(1);
      sample_strobe <= 1'b0;
      tick(1);
   endtask
   task pulse(input logic [2:0] w);
      {results_ready, calib_done, tamper_event} <= w;
      tick(1);
      {results_ready, calib_done, tamper_event} <= 3'b000;
      tick(1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_cross();
      rd(ADDR_STATUS, 32'h0, "status after reset");
      undervoltage_seen <= 1'b1;
      strobe(1'b0);
      strobe(1'b1);
      chk(32'({flags[FB_SAMPLE], flags[FB_LEAD], flags[FB_TRAIL]}), 32'h5, "trailing");
      wr(ADDR_COMMAND, 32'h1);
      strobe(1'b1);
      chk(32'({flags[FB_SAMPLE], flags[FB_TRAIL]}), 32'h3, "trail held, sample new");
      strobe(1'b0);
      chk(32'({flags[FB_LEAD], flags[FB_TRAIL]}), 32'h2, "leading");
      chk(32'(flags[FB_UNDERV]), 32'h1, "undervoltage after trailing");
      chk(32'(line_cycle_counter), 32'h1, "line cycles");
   endtask
   task t_tamper();
      pulse(3'b001);
      wr(ADDR_COMMAND, 32'h1);
      wr(ADDR_STATUS, 32'h0);
      chk(32'(flags[FB_TAMPER]), 32'h1, "tamper held");
      rd(8'h40, 32'h0, "unmapped read");
      chk(32'(pe), 32'h1, "unmapped error");
   endtask
   task t_level();
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_CONTROL, 32'(m));
         // A large step in count mode shows that the step is ignored there
         energy_step <= m ? 16'h0005 : 16'h0001;
         wr(ADDR_LEVEL, 32'h2);
         pulse(3'b100);
         chk(32'({flags[FB_LEVEL], flags[FB_ENRDY]}), 32'h1, "one result");
         pulse(3'b100);
         chk(32'(flags[FB_LEVEL]), 32'h1, "level reached");
         wr(ADDR_COMMAND, 32'h1);
         chk(32'({flags[FB_TAMPER], flags[FB_LEAD], flags[FB_SAMPLE], flags[FB_LEVEL],
             flags[FB_ENRDY]}), 32'h18, "clear event");
      end
   endtask
   task t_larger();
      current_b_larger <= 1'b1;
      wr(ADDR_CONTROL, 32'h0);
      strobe(1'b0);
      chk(32'(flags[FB_LARGER]), 32'h0, "larger while off");
      wr(ADDR_CONTROL, 32'h2);
      strobe(1'b0);
      tick(2);
      chk(32'(flags[FB_LARGER]), 32'h1, "larger while on");
   endtask
   task t_msg();
      wr(ADDR_EVENT_EN, 32'h0);
      wr(ADDR_COMMAND, 32'h1);
      strobe(1'b1);
      chk(32'({message_pending, flags[FB_SAMPLE]}), 32'h1, "flag without message");
      wr(ADDR_EVENT_EN, 32'h80);
      wr(ADDR_COMMAND, 32'h1);
      strobe(1'b0);
      tick(1);
      chk(32'(message_pending), 32'h1, "message raised");
      rd(ADDR_MSG, 32'h80, "message word");
      chk(32'({message_pending, flags[FB_SAMPLE]}), 32'h0, "sent clears sample");
   endtask
   task t_cal();
      pulse(3'b010);
      chk(32'(flags[FB_CALRDY]), 32'h0, "calibration outside mode");
      engine_mode <= MSF_CALIB;
      pulse(3'b010);
      chk(32'(flags[FB_CALRDY]), 32'h1, "calibration done");
      engine_mode <= MSF_IDLE;
      tick(2);
      chk(32'(flags[FB_CALRDY]), 32'h0, "idle clears");
   endtask
   task t_period();
      int t0;
      t0 = temp_cnt;
      wr(ADDR_CONTROL, 32'h0);
      wave <= 16'h0000;
      undervoltage_seen <= 1'b0;
      pulse(3'b100);
      strobe(1'b1);
      chk(32'(flags[FB_UNDERV]), 32'h0, "undervoltage cleared");
      pulse(3'b100);
      strobe(1'b0);
      tick(1);
      chk(32'(temp_cnt - t0), 32'h2, "temperature starts");
      // One period of five samples, the leading crossing sample included
      strobe(1'b0);
      strobe(1'b0);
      strobe(1'b1);
      strobe(1'b1);
      strobe(1'b0);
      chk(32'(mains_period_value), 32'h5, "mains period");
      chk(32'({voltage_peak_register, current_peak_register}), 32'h0606_0606, "peaks");
      chk(period_active_energy_a, 32'h0000_1414, "period energy a");
      chk(period_active_energy_b, 32'hffff_ebe7, "period energy b");
      // Fill the load window with 1000 inductive periods, the rest capacitive
      for (int k = 0; k < 4096 && load_type_register == ZERO16; k++) begin
         capacitive_load <= (k >= 1000);
         strobe(1'b1);
         strobe(1'b0);
      end
      capacitive_load <= 1'b1;
      chk(32'(load_type_register), 32'h0830, "load type");
      chk(32'(line_cycle_counter), 32'h1000, "line cycles per window");
   endtask
   task complete_run();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      tick(16);
      rst_n <= 1'b1;
      tick(1);
      t_cross();
      t_tamper();
      t_level();
      t_larger();
      t_msg();
      t_cal();
      t_period();
      complete_run();
   end
endmodule
